// *** rtl/eewsg_defines.svh ***
// Constants for the EEPROM write-stretch glue
`ifndef EEWSG_DEFINES_SVH
`define EEWSG_DEFINES_SVH

// ****************************************************************
// Timing
// ****************************************************************
`define EEWSG_MCLK_NS        100
`define EEWSG_RECOVERY_NS    200
`define EEWSG_RECOVERY_CYC   ((`EEWSG_RECOVERY_NS + `EEWSG_MCLK_NS - 1) \
                              / `EEWSG_MCLK_NS)
`define EEWSG_NOWAIT_MAX_MHZ 6

// ****************************************************************
// Reset values
// ****************************************************************
`define EEWSG_GATE_RST       1'b1
`define EEWSG_CE_RST         1'b1
`define EEWSG_OE_RST         1'b1

`endif

// *** rtl/eewsg_pkg.sv ***
// Types shared by the EEPROM write-stretch glue
`default_nettype none
package eewsg_pkg;

    // Program-gate sequencer phases
    typedef enum logic [1:0] {
        EEWSG_IDLE,
        EEWSG_ARMED,
        EEWSG_PROG,
        EEWSG_TERM
    } eewsg_phase_e;

    // Program-gate latch state
    typedef struct packed {
        eewsg_phase_e phase;
        logic         clk_q;
        logic         store_q;
        logic         fetch_q;
    } eewsg_gate_s;

endpackage
`default_nettype wire

// *** rtl/eewsg_gate_if.sv ***
// Bundle between the glue top and its program-gate latch
`default_nettype none
interface eewsg_gate_if;
    logic hit;
    logic store_n;
    logic fetch_n;
    logic cpu_clk;
    logic strobe_mode;
    logic gate_n;
    logic term_pend;

    modport ctl  (output hit, store_n, fetch_n, cpu_clk, strobe_mode,
                  input  gate_n, term_pend);
    modport gate (input  hit, store_n, fetch_n, cpu_clk, strobe_mode,
                  output gate_n, term_pend);
endinterface
`default_nettype wire

// *** rtl/eewsg_gate.sv ***
// Program-gate latch with arm, write-reset and preset sequencing
`default_nettype none
module eewsg_gate (
    input  wire logic  mclk,
    input  wire logic  reset_n,
    input  wire logic  clk_en,
    eewsg_gate_if.gate g
);

    eewsg_pkg::eewsg_gate_s s;
    eewsg_pkg::eewsg_gate_s next_s;
    logic                   fall_clk;
    logic                   fall_store;
    logic                   rise_fetch;

    // ************************************************************
    // Edge detection on processor strobes
    // ************************************************************
    assign fall_clk   = s.clk_q & ~g.cpu_clk;
    assign fall_store = s.store_q & ~g.store_n;
    assign rise_fetch = ~s.fetch_q & g.fetch_n;

    // Gate is low while programming or awaiting the terminating read
    assign g.gate_n    = !(s.phase == eewsg_pkg::EEWSG_PROG ||
                           s.phase == eewsg_pkg::EEWSG_TERM);
    assign g.term_pend = (s.phase == eewsg_pkg::EEWSG_TERM);

    // ************************************************************
    // Sequencer
    // ************************************************************
    always_comb begin
        next_s         = s;
        next_s.clk_q   = g.cpu_clk;
        next_s.store_q = g.store_n;
        next_s.fetch_q = g.fetch_n;
        case (s.phase)
            eewsg_pkg::EEWSG_IDLE: begin
                if (g.strobe_mode) begin
                    if (fall_store && g.hit)
                        next_s.phase = eewsg_pkg::EEWSG_PROG;
                end else if (!g.store_n && g.hit) begin
                    next_s.phase = eewsg_pkg::EEWSG_ARMED;
                end
            end
            eewsg_pkg::EEWSG_ARMED: begin
                // Arming lapses if the store ends before a clock fall
                if (fall_clk)
                    next_s.phase = eewsg_pkg::EEWSG_PROG;
                else if (g.store_n)
                    next_s.phase = eewsg_pkg::EEWSG_IDLE;
            end
            eewsg_pkg::EEWSG_PROG: begin
                // Held for the whole programming time until a read
                if (!g.fetch_n && g.hit)
                    next_s.phase = eewsg_pkg::EEWSG_TERM;
            end
            eewsg_pkg::EEWSG_TERM: begin
                if (rise_fetch)
                    next_s.phase = eewsg_pkg::EEWSG_IDLE;
            end
            default: next_s.phase = eewsg_pkg::EEWSG_IDLE;
        endcase
    end

    // Gate must come up high so nothing writes before the first store
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            s.phase   <= eewsg_pkg::EEWSG_IDLE;
            s.clk_q   <= 1'b0;
            s.store_q <= 1'b1;
            s.fetch_q <= 1'b1;
        end else if (clk_en) begin
            s <= next_s;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    a_clk_fall_arm: assert property (
        clk_en && s.phase == eewsg_pkg::EEWSG_ARMED && fall_clk
        |=> !g.gate_n)
        else $error("gate not lowered on clock fall");

    a_strobe_fall_gate: assert property (
        clk_en && g.strobe_mode && s.phase == eewsg_pkg::EEWSG_IDLE
        && fall_store && g.hit |=> !g.gate_n)
        else $error("gate not lowered on store fall");

    a_gate_held_low: assert property (
        !g.gate_n && g.fetch_n && !g.term_pend |=> !g.gate_n)
        else $error("gate released without a read");

    a_fetch_rise_ends: assert property (
        clk_en && g.term_pend && rise_fetch |=> g.gate_n)
        else $error("gate not preset at fetch rise");

endmodule
`default_nettype wire

// *** rtl/eewsg_top.sv ***
// EEPROM write-stretch glue between a processor bus and byte-wide memories
`default_nettype none
`include "eewsg_defines.svh"

// Behaviour
// - A decoded address hit selects the memory by pulling chip select low.
// - Clocked mode: store strobe arms the gate, next processor clock fall drops it.
// - Gate falls while address, data and control are held valid.
// - Chip select stays low only briefly in a write; its rise latches data.
// - Once low, the gate stays low until a terminating read.
// - A read during a pending write sets a write-reset latch.
// - Ordinary reads look the same for both memory types.
// - Strobe mode: falling store strobe with a hit drops the gate.
// - Strobe mode: address and control are stable when the gate falls.
// - Strobe mode: chip select is forced high within the same write cycle.
// - During the terminating read chip select is held high.
// - Fetch strobe rise with the reset latch set presets the gate high.
// - After gate rise chip select may pulse briefly for write recovery.
// - Normal reads assert chip select and the fetch strobe enables outputs.
// - Strobe mode needs no wait states up to 6 MHz processor clock.
// - Multiplexed address bits are latched before decode and the memory.
// - A 16-bit bus drives two byte memories in parallel, whole words.
module eewsg_top #(
    parameter int          ADDR_W = 20,
    parameter int          DATA_W = 16,
    parameter int          MEM_AW = 13,
    parameter logic [5:0]  BASE   = 6'h3f
) (
    input  wire logic                       mclk,
    input  wire logic                       reset_n,
    input  wire logic                       clk_en,
    input  wire logic                       strobe_mode,
    input  wire logic                       cpu_clk,
    input  wire logic                       ale,
    input  wire logic                       store_n,
    input  wire logic                       fetch_n,
    input  wire logic [ADDR_W-DATA_W-1:0]   addr_hi,
    input  wire logic [DATA_W-1:0]          ad_in,
    output logic      [DATA_W-1:0]          ad_out,
    output logic                            ad_oe_n,
    output logic      [MEM_AW-1:0]          mem_addr,
    input  wire logic [DATA_W-1:0]          mem_d_in,
    output logic      [DATA_W-1:0]          mem_d_out,
    output logic                            mem_d_oe_n,
    output logic                            mem_ce_n,
    output logic                            mem_we_n,
    output logic                            mem_oe_n
);

    localparam int          DEC_W = ADDR_W - MEM_AW - 1;
    localparam logic [2:0]  REC_CYC = 3'(`EEWSG_RECOVERY_CYC);

    // Whole state of the top in one record
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic [DATA_W-1:0] rdata;
        logic              ad_oe_n;
        logic              d_oe_n;
        logic              ce_n;
        logic              we_n;
        logic              oe_n;
        logic              gate_q;
        logic [2:0]        rec_cnt;
    } eewsg_top_s;

    eewsg_top_s   s;
    eewsg_top_s   next_s;
    logic         hit;
    logic         write_on;
    logic         norm_read;
    eewsg_gate_if g ();

    // ************************************************************
    // Address decode and program-gate latch
    // ************************************************************
    // Decode looks only at the latched address, never the live bus
    assign hit = (s.addr[ADDR_W-1:MEM_AW+1] == BASE[DEC_W-1:0]);

    assign g.hit         = hit;
    assign g.store_n     = store_n;
    assign g.fetch_n     = fetch_n;
    assign g.cpu_clk     = cpu_clk;
    assign g.strobe_mode = strobe_mode;

    eewsg_gate u_gate (
        .mclk    (mclk),
        .reset_n (reset_n),
        .clk_en  (clk_en),
        .g       (g)
    );

    // Write window lasts only until the gate drops
    assign write_on  = hit && !store_n && g.gate_n;
    // Read with no pending write is an ordinary access
    assign norm_read = hit && !fetch_n && g.gate_n;

    // ************************************************************
    // Bus and memory strobes
    // ************************************************************
    always_comb begin
        next_s        = s;
        next_s.gate_q = g.gate_n;
        // Multiplexed address captured while ALE is high
        if (ale)
            next_s.addr = {addr_hi, ad_in};
        // Data frozen once the gate falls so both edges see it
        if (write_on)
            next_s.wdata = ad_in;
        // Recovery window opens as the gate rises
        if (!s.gate_q && g.gate_n)
            next_s.rec_cnt = REC_CYC;
        else if (s.rec_cnt != 3'h0)
            next_s.rec_cnt = s.rec_cnt - 3'h1;
        // Pending gate keeps chip select off during the ending read
        next_s.ce_n = !(write_on || norm_read ||
                        (hit && s.rec_cnt != 3'h0 && g.gate_n));
        next_s.we_n    = g.gate_n;
        next_s.oe_n    = !norm_read;
        next_s.d_oe_n  = !(hit && !store_n);
        next_s.ad_oe_n = !norm_read;
        next_s.rdata   = mem_d_in;
    end

    // Single state register; strobe mode reacts within one cycle
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            s.addr    <= '0;
            s.wdata   <= '0;
            s.rdata   <= '0;
            s.ad_oe_n <= 1'b1;
            s.d_oe_n  <= 1'b1;
            s.ce_n    <= `EEWSG_CE_RST;
            s.we_n    <= `EEWSG_GATE_RST;
            s.oe_n    <= `EEWSG_OE_RST;
            s.gate_q  <= `EEWSG_GATE_RST;
            s.rec_cnt <= 3'h0;
        end else if (clk_en) begin
            s <= next_s;
        end
    end

    // Outputs straight from the state record
    assign ad_out     = s.rdata;
    assign ad_oe_n    = s.ad_oe_n;
    assign mem_addr   = s.addr[MEM_AW:1];
    assign mem_d_out  = s.wdata;
    assign mem_d_oe_n = s.d_oe_n;
    assign mem_ce_n   = s.ce_n;
    assign mem_we_n   = s.we_n;
    assign mem_oe_n   = s.oe_n;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    sequence s_term_open;
        clk_en && !g.gate_n && hit && !fetch_n;
    endsequence

    sequence s_gate_rise;
        clk_en && g.gate_n && !s.gate_q && hit;
    endsequence

    a_read_selects: assert property (
        clk_en && norm_read |=> !mem_ce_n && !mem_oe_n && !ad_oe_n)
        else $error("normal read did not select memory");

    a_write_selects: assert property (
        clk_en && write_on |=> !mem_ce_n && mem_oe_n)
        else $error("write did not select memory");

    a_ce_rise_we_fall: assert property (
        $fell(mem_we_n) |-> mem_ce_n)
        else $error("chip select low as gate fell");

    a_we_follows_gate: assert property (
        clk_en && !g.gate_n |=> !mem_we_n)
        else $error("write enable not tracking gate");

    a_term_read_block: assert property (
        s_term_open |=> mem_ce_n && mem_oe_n)
        else $error("chip select active in ending read");

    a_term_sets_latch: assert property (
        s_term_open |=> g.term_pend)
        else $error("write reset latch not set");

    // Recovery select trails the write enable rise by one cycle, so the
    // part never sees chip select fall while write enable is still low
    a_recover_select: assert property (
        s_gate_rise |=> ##1 !mem_ce_n && mem_oe_n)
        else $error("no recovery select after gate rise");

    // Chip select must lift the cycle after the gate has dropped
    a_ce_drops_prog: assert property (
        clk_en && !mem_ce_n && !g.gate_n |=> mem_ce_n)
        else $error("chip select held low while programming");

    a_data_held_prog: assert property (
        clk_en && !g.gate_n && !store_n |=> $stable(mem_d_out))
        else $error("write data moved while programming");

    a_addr_latched: assert property (
        clk_en && ale |=> mem_addr == $past(ad_in[MEM_AW:1]))
        else $error("address not latched on ale");

endmodule
`default_nettype wire

// *** sim/eewsg_mem_model.sv ***
// Behavioural model of the paired byte-wide memories behind the glue
`default_nettype none
module eewsg_mem_model (
    input  wire logic        mclk,
    input  wire logic [12:0] mem_addr,
    input  wire logic [15:0] mem_d_out,
    output logic      [15:0] mem_d_in,
    input  wire logic        mem_ce_n,
    input  wire logic        mem_we_n,
    input  wire logic        mem_oe_n,
    output logic      [15:0] lat_d,
    output logic      [15:0] tim_d
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [15:0] arr [0:15];
    logic [15:0] junk = 16'h5a5a;

    // Latched-type part: address, data and control taken as the gate falls
    always @(negedge mem_we_n) begin
        arr[mem_addr[3:0]] = mem_d_out;
        lat_d = mem_d_out;
    end

    // Timer-type part: data taken on the rising chip select
    always @(posedge mem_ce_n) begin
        tim_d = mem_d_out;
    end

    // An idle bus must not hold its last value, or a late sample passes
    always @(posedge mclk) begin
        junk <= ~mem_d_in;
    end

    // Outputs only while selected, enabled and not writing
    assign mem_d_in = (!mem_ce_n && !mem_oe_n && mem_we_n) ?
                      arr[mem_addr[3:0]] : junk;
endmodule
`default_nettype wire

// *** sim/eeprom_write_stretch_glue_tb.sv ***
// Self-checking bench for the EEPROM write-stretch glue
`default_nettype none
module eeprom_write_stretch_glue_tb;
    timeunit 1ns;
    timeprecision 1ns;

    logic        mclk        = 1'h0;
    logic        reset_n     = 1'h0;
    logic        clk_en      = 1'h1;
    logic        strobe_mode = 1'h1;
    logic        cpu_clk     = 1'h1;
    logic        ale         = 1'h0;
    logic        store_n     = 1'h1;
    logic        fetch_n     = 1'h1;
    logic [3:0]  addr_hi     = 4'h0;
    logic [15:0] ad_in       = 16'h0;
    logic [15:0] ad_out;
    logic [15:0] mem_d_in;
    logic [15:0] mem_d_out;
    logic [15:0] lat_d;
    logic [15:0] tim_d;
    logic [12:0] mem_addr;
    logic        ad_oe_n;
    logic        mem_d_oe_n;
    logic        mem_ce_n;
    logic        mem_we_n;
    logic        mem_oe_n;
    int          n_fail      = 0;
    int          checked     = 0;

    // 10 MHz system clock
    always #50 mclk = ~mclk;

    eewsg_top u_dut (
        .mclk(mclk), .reset_n(reset_n), .clk_en(clk_en),
        .strobe_mode(strobe_mode), .cpu_clk(cpu_clk), .ale(ale),
        .store_n(store_n), .fetch_n(fetch_n), .addr_hi(addr_hi),
        .ad_in(ad_in), .ad_out(ad_out), .ad_oe_n(ad_oe_n),
        .mem_addr(mem_addr), .mem_d_in(mem_d_in), .mem_d_out(mem_d_out),
        .mem_d_oe_n(mem_d_oe_n), .mem_ce_n(mem_ce_n),
        .mem_we_n(mem_we_n), .mem_oe_n(mem_oe_n)
    );

    eewsg_mem_model u_mem (
        .mclk(mclk), .mem_addr(mem_addr), .mem_d_out(mem_d_out),
        .mem_d_in(mem_d_in), .mem_ce_n(mem_ce_n), .mem_we_n(mem_we_n),
        .mem_oe_n(mem_oe_n), .lat_d(lat_d), .tim_d(tim_d)
    );

    // ************************************************************
    // Shared helpers
    // ************************************************************
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: saw %h expected %h",
                     $time, seen, exp);
        end
    endtask

    // Inputs move only at the falling edge, away from sampling
    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask

    // Address phase on the shared bus, then the data word
    task automatic addr_phase(input logic [15:0] lo, input logic [15:0] d);
        addr_hi = 4'hf;
        ad_in = lo;
        ale = 1'h1;
        cyc(1);
        ale = 1'h0;
        ad_in = d;
    endtask

    task automatic complete_run;
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_reset;
        chk(mem_ce_n, 1'h1);
        chk(mem_we_n, 1'h1);
        chk(ad_oe_n, 1'h1);
    endtask

    task automatic t_strobe_write;
        strobe_mode = 1'h1;
        addr_phase(16'hc00a, 16'ha55a);
        store_n = 1'h0;
        cyc(1);
        chk(mem_ce_n, 1'h0);
        chk(mem_d_oe_n, 1'h0);
        cyc(1);
        chk(mem_we_n, 1'h0);
        chk(mem_ce_n, 1'h1);
        chk(mem_addr, 13'h5);
        chk(lat_d, 16'ha55a);
        chk(tim_d, 16'ha55a);
        store_n = 1'h1;
        cyc(40);
        chk(mem_we_n, 1'h0);
        // A second store while programming must not reselect the part
        store_n = 1'h0;
        cyc(3);
        chk(mem_ce_n, 1'h1);
        store_n = 1'h1;
        cyc(1);
    endtask

    // Frozen glue must ignore a read, so the write keeps going
    task automatic t_freeze;
        clk_en = 1'h0;
        fetch_n = 1'h0;
        cyc(2);
        chk(mem_we_n, 1'h0);
        chk(mem_ce_n, 1'h1);
        fetch_n = 1'h1;
        cyc(2);
        clk_en = 1'h1;
        cyc(2);
        chk(mem_we_n, 1'h0);
    endtask

    // One discarded read ends the write; its data is never used
    task automatic t_terminate;
        fetch_n = 1'h0;
        cyc(2);
        chk(mem_ce_n, 1'h1);
        chk(ad_oe_n, 1'h1);
        fetch_n = 1'h1;
        cyc(1);
        chk(mem_we_n, 1'h0);
        cyc(1);
        chk(mem_we_n, 1'h1);
        chk(mem_ce_n, 1'h1);
        cyc(1);
        chk(mem_oe_n, 1'h1);
        if (strobe_mode) begin
            chk(mem_ce_n, 1'h0);
        end
        cyc(3);
    endtask

    task automatic t_verify(input logic [15:0] d);
        fetch_n = 1'h0;
        cyc(2);
        chk(mem_ce_n, 1'h0);
        chk(mem_d_oe_n, 1'h1);
        chk(mem_oe_n, 1'h0);
        chk(ad_oe_n, 1'h0);
        cyc(1);
        chk(ad_out, d);
        fetch_n = 1'h1;
        cyc(3);
    endtask

    // Gate must wait for the processor clock to fall, not the strobe
    task automatic t_clocked_write;
        strobe_mode = 1'h0;
        cpu_clk = 1'h1;
        addr_phase(16'hc00c, 16'h3cc3);
        store_n = 1'h0;
        cyc(4);
        chk(mem_we_n, 1'h1);
        cpu_clk = 1'h0;
        cyc(1);
        chk(mem_we_n, 1'h1);
        cyc(1);
        chk(mem_we_n, 1'h0);
        chk(mem_ce_n, 1'h1);
        chk(lat_d, 16'h3cc3);
        chk(mem_addr, 13'h6);
        cpu_clk = 1'h1;
        store_n = 1'h1;
        cyc(40);
    endtask

    // Main sequence: reset held two cycles, then both variants
    initial begin
        cyc(2);
        reset_n = 1'h1;
        cyc(1);
        t_reset();
        t_strobe_write();
        t_freeze();
        t_terminate();
        t_verify(16'ha55a);
        t_clocked_write();
        t_terminate();
        t_verify(16'h3cc3);
        complete_run();
    end

    // Whole run needs about 130 cycles; over ten times that means a hang
    initial begin
        cyc(1500);
        n_fail++;
        complete_run();
    end
endmodule
`default_nettype wire
